// [src/scs_pkg.sv]
// shared constants and types of the serial configuration port
package scs_pkg;
  // ----------------------------------------
  // word and clock
  // ----------------------------------------
  localparam int WORD_W = 20;
  localparam int CLK_NS = 8;
  localparam int FILT_NS = 12;
  localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCK_HALF_NS = 200;
  localparam int SCK_HALF_CYC = SCK_HALF_NS / CLK_NS;
  // ----------------------------------------
  // input filter bank: 0 sck, 1 sdi, 2 chip select, 3 driver enable
  // ----------------------------------------
  localparam int N_IN = 4;
  localparam int IN_SCK = 0;
  localparam int IN_SDI = 1;
  localparam int IN_CS = 2;
  localparam int IN_EN = 3;
  localparam logic [3:0] IN_RST = 4'hC;
  // ----------------------------------------
  // control word layout
  // ----------------------------------------
  localparam int N_RB_SEL = 4;
  localparam int CFG_TAG_LSB = 17;
  localparam logic [2:0] CFG_TAG = 3'h7;
  localparam int RB_SEL_LSB = 4;
  localparam logic [1:0] RB_SEL_RST = 2'h0;
  localparam logic [19:0] CTRL_RST = 20'h00000;
  // ----------------------------------------
  // master states
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LOW  = 5'h02,
    ST_HIGH = 5'h04,
    ST_HOLD = 5'h08,
    ST_GAP  = 5'h10
  } scs_state_t;
endpackage

// [src/scs_link_if.sv]
// serial link wires between master and configuration port
`timescale 1ns/1ps
`default_nettype none
interface scs_link_if;
  logic sck;
  logic sdi;
  logic sdo;
  logic chip_select_low;
  logic driver_enable_low;
  modport dev (input sck, input sdi, input chip_select_low, input driver_enable_low, output sdo);
  modport host (output sck, output sdi, output chip_select_low, output driver_enable_low,
                input sdo);
endinterface
`default_nettype wire

// [src/scs_dev.sv]
// device end: oversampled serial configuration port
`timescale 1ns/1ps
`default_nettype none
module scs_dev #(
  parameter int W = scs_pkg::WORD_W
) (
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  scs_link_if.dev LINK,
  input wire logic [scs_pkg::N_RB_SEL-1:0][W-1:0] STATUS_I,
  output logic [W-1:0] CTRL_O,
  output logic CTRL_STB_O,
  output logic [1:0] RB_SEL_O,
  output logic DRV_EN_O
);
  // ----------------------------------------
  // synchronisers and glitch filters
  // ----------------------------------------
  logic [scs_pkg::N_IN-1:0] pin_in;
  logic [scs_pkg::N_IN-1:0] s1_r;
  logic [scs_pkg::N_IN-1:0] s2_r;
  logic [scs_pkg::N_IN-1:0] filt_r;
  logic [3:0] fcnt_r [scs_pkg::N_IN];

  assign pin_in = {LINK.driver_enable_low, LINK.chip_select_low, LINK.sdi, LINK.sck};

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      s1_r <= scs_pkg::IN_RST;
      s2_r <= scs_pkg::IN_RST;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < scs_pkg::N_IN; gi++) begin : g_filt
      always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
          filt_r[gi] <= scs_pkg::IN_RST[gi];
          fcnt_r[gi] <= 4'h0;
        end else if (s2_r[gi] == filt_r[gi]) begin
          fcnt_r[gi] <= 4'h0;
        end else if (fcnt_r[gi] == 4'(scs_pkg::FILT_CYC - 1)) begin
          filt_r[gi] <= s2_r[gi];
          fcnt_r[gi] <= 4'h0;
        end else begin
          fcnt_r[gi] <= fcnt_r[gi] + 4'h1;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // edge detection
  // ----------------------------------------
  logic sck_d_r;
  logic cs_d_r;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic active;

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      sck_d_r <= filt_r[scs_pkg::IN_SCK];
      cs_d_r <= filt_r[scs_pkg::IN_CS];
    end
  end

  assign active = ~filt_r[scs_pkg::IN_CS];
  assign sck_rise = filt_r[scs_pkg::IN_SCK] & ~sck_d_r & active;
  assign sck_fall = ~filt_r[scs_pkg::IN_SCK] & sck_d_r & active;
  assign cs_fall = ~filt_r[scs_pkg::IN_CS] & cs_d_r;
  assign cs_rise = filt_r[scs_pkg::IN_CS] & ~cs_d_r;

  // ----------------------------------------
  // shift register and serial out
  // ----------------------------------------
  logic [W-1:0] sr_r;
  logic sdo_r;
  logic [1:0] rb_sel_r;

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      sr_r <= '0;
    end else if (cs_fall) begin
      sr_r <= STATUS_I[rb_sel_r];
    end else if (sck_rise) begin
      sr_r <= {sr_r[W-2:0], filt_r[scs_pkg::IN_SDI]};
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      sdo_r <= 1'b0;
    end else if (cs_fall) begin
      sdo_r <= STATUS_I[rb_sel_r][W-1];
    end else if (sck_fall) begin
      sdo_r <= sr_r[W-1];
    end
  end

  assign LINK.sdo = sdo_r;

  // ----------------------------------------
  // control register latch
  // ----------------------------------------
  logic [W-1:0] ctrl_r;
  logic stb_r;
  logic drv_en_r;

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      ctrl_r <= W'(scs_pkg::CTRL_RST);
      stb_r <= 1'b0;
    end else begin
      stb_r <= cs_rise;
      if (cs_rise) begin
        ctrl_r <= sr_r;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      rb_sel_r <= scs_pkg::RB_SEL_RST;
    end else if (cs_rise && sr_r[scs_pkg::CFG_TAG_LSB +: 3] == scs_pkg::CFG_TAG) begin
      rb_sel_r <= sr_r[scs_pkg::RB_SEL_LSB +: 2];
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      drv_en_r <= 1'b0;
    end else begin
      drv_en_r <= ~filt_r[scs_pkg::IN_EN];
    end
  end

  assign CTRL_O = ctrl_r;
  assign CTRL_STB_O = stb_r;
  assign RB_SEL_O = rb_sel_r;
  assign DRV_EN_O = drv_en_r;
endmodule // scs_dev
`default_nettype wire

// [src/scs_host.sv]
// master end: buffered command words sent over the serial link
`timescale 1ns/1ps
`default_nettype none
module scs_host #(
  parameter int W = scs_pkg::WORD_W,
  parameter int HALF = scs_pkg::SCK_HALF_CYC
) (
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  scs_link_if.host LINK,
  input wire logic CMD_VALID_I,
  input wire logic [W-1:0] CMD_DATA_I,
  output logic CMD_READY_O,
  output logic RESP_VALID_O,
  output logic [W-1:0] RESP_DATA_O,
  input wire logic DRV_EN_I
);
  // ----------------------------------------
  // two-entry command buffer
  // ----------------------------------------
  logic [W-1:0] mem_r [2];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic ready_r;
  logic push;
  logic pop;
  scs_pkg::scs_state_t st_r;

  assign push = CMD_VALID_I & ready_r;
  assign pop = (st_r == scs_pkg::ST_IDLE) && (cnt_r != 2'h0);
  assign cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
      ready_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      ready_r <= (cnt_nxt != 2'h2);
      if (push) begin
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (push) begin
      mem_r[wp_r] <= CMD_DATA_I;
    end
  end

  // ----------------------------------------
  // serial data in synchroniser
  // ----------------------------------------
  logic sdo_s1_r;
  logic sdo_s2_r;

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      sdo_s1_r <= 1'b0;
      sdo_s2_r <= 1'b0;
    end else begin
      sdo_s1_r <= LINK.sdo;
      sdo_s2_r <= sdo_s1_r;
    end
  end

  // ----------------------------------------
  // transfer sequencer
  // ----------------------------------------
  logic [15:0] tc_r;
  logic [7:0] bit_r;
  logic [W-1:0] tx_r;
  logic [W-1:0] rx_r;
  logic sck_r;
  logic sdi_r;
  logic cs_low_r;
  logic en_low_r;
  logic resp_v_r;
  logic [W-1:0] resp_r;
  logic half_done;

  assign half_done = (tc_r == 16'(HALF - 1));

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      st_r <= scs_pkg::ST_IDLE;
      tc_r <= 16'h0000;
      bit_r <= 8'h00;
      tx_r <= '0;
      rx_r <= '0;
      sck_r <= 1'b0;
      sdi_r <= 1'b0;
      cs_low_r <= 1'b1;
      resp_v_r <= 1'b0;
      resp_r <= '0;
    end else begin
      resp_v_r <= 1'b0;
      tc_r <= half_done ? 16'h0000 : tc_r + 16'h0001;
      unique case (st_r)
        scs_pkg::ST_IDLE: begin
          tc_r <= 16'h0000;
          if (pop) begin
            tx_r <= mem_r[rp_r];
            sdi_r <= mem_r[rp_r][W-1];
            cs_low_r <= 1'b0;
            bit_r <= 8'h00;
            st_r <= scs_pkg::ST_LOW;
          end
        end
        scs_pkg::ST_LOW: begin
          if (half_done) begin
            sck_r <= 1'b1;
            rx_r <= {rx_r[W-2:0], sdo_s2_r};
            st_r <= scs_pkg::ST_HIGH;
          end
        end
        scs_pkg::ST_HIGH: begin
          if (half_done) begin
            sck_r <= 1'b0;
            if (bit_r == 8'(W - 1)) begin
              st_r <= scs_pkg::ST_HOLD;
            end else begin
              bit_r <= bit_r + 8'h01;
              tx_r <= {tx_r[W-2:0], 1'b0};
              sdi_r <= tx_r[W-2];
              st_r <= scs_pkg::ST_LOW;
            end
          end
        end
        scs_pkg::ST_HOLD: begin
          if (half_done) begin
            cs_low_r <= 1'b1;
            st_r <= scs_pkg::ST_GAP;
          end
        end
        scs_pkg::ST_GAP: begin
          if (half_done) begin
            resp_r <= rx_r;
            resp_v_r <= 1'b1;
            st_r <= scs_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      en_low_r <= 1'b1;
    end else begin
      en_low_r <= ~DRV_EN_I;
    end
  end

  assign LINK.sck = sck_r;
  assign LINK.sdi = sdi_r;
  assign LINK.chip_select_low = cs_low_r;
  assign LINK.driver_enable_low = en_low_r;
  assign CMD_READY_O = ready_r;
  assign RESP_VALID_O = resp_v_r;
  assign RESP_DATA_O = resp_r;
endmodule // scs_host
`default_nettype wire

// [bench/scs_link_assertions.sv]
// link protocol checks between the two serial ends
`timescale 1ns/1ps
`default_nettype none
module scs_link_assertions (
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic chip_select_low,
  input wire logic driver_enable_low
);
  // ----------------------------------------
  // sck rises counted per frame
  // ----------------------------------------
  logic [5:0] cnt_r;
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I || chip_select_low)
      cnt_r <= 6'h00;
    else if ($rose(sck))
      cnt_r <= cnt_r + 6'h01;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);
  a_sck_idle_low: assert property (chip_select_low |-> !sck)
    else $error("sck high outside frame");
  a_cs_setup: assert property ($fell(chip_select_low) |-> !sck [*8])
    else $error("sck rose too soon after select");
  a_cs_high_min: assert property ($rose(chip_select_low) |-> chip_select_low [*8])
    else $error("select high time too short");
  a_frame_bound: assert property ($fell(chip_select_low) |-> ##[1:1000] chip_select_low)
    else $error("frame never ended");
  a_sck_high_min: assert property ($rose(sck) |-> sck [*8])
    else $error("sck high time too short");
  a_sck_low_min: assert property ($fell(sck) |-> !sck [*8])
    else $error("sck low time too short");
  a_sdi_held: assert property ($rose(sck) |-> $stable(sdi) ##1 $stable(sdi))
    else $error("sdi moved at sck rise");
  a_sdo_on_low: assert property (!chip_select_low && $changed(sdo) |-> !sck)
    else $error("sdo changed while sck high");
  a_pulse_count: assert property ($rose(chip_select_low) |-> cnt_r == 6'h14)
    else $error("frame without 20 sck pulses");
endmodule // scs_link_assertions
`default_nettype wire

// [bench/tb.sv]
// self-checking bench for the serial configuration port pair
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk;
  logic nrst;
  logic cmd_valid;
  logic [19:0] cmd_data;
  logic cmd_ready;
  logic resp_valid;
  logic [19:0] resp_data;
  logic drv_en;
  logic [3:0][19:0] status;
  logic [19:0] ctrl;
  logic ctrl_stb;
  logic [1:0] rb_sel;
  logic drv_en_o;
  logic [19:0] exp_ctrl[$];
  logic [19:0] exp_resp[$];
  logic [1:0] sel;
  int err_count;
  int n_tests;
  int r;
  scs_link_if link ();
  scs_host #(.HALF(10)) scs_host_i (.CLK_SYS_I(clk), .NRST_I(nrst), .LINK(link.host),
    .CMD_VALID_I(cmd_valid), .CMD_DATA_I(cmd_data), .CMD_READY_O(cmd_ready),
    .RESP_VALID_O(resp_valid), .RESP_DATA_O(resp_data), .DRV_EN_I(drv_en));
  scs_dev scs_dev_i (.CLK_SYS_I(clk), .NRST_I(nrst), .LINK(link.dev), .STATUS_I(status),
    .CTRL_O(ctrl), .CTRL_STB_O(ctrl_stb), .RB_SEL_O(rb_sel), .DRV_EN_O(drv_en_o));
  scs_link_assertions scs_link_assertions_i (.CLK_SYS_I(clk), .NRST_I(nrst), .sck(link.sck),
    .sdi(link.sdi), .sdo(link.sdo), .chip_select_low(link.chip_select_low),
    .driver_enable_low(link.driver_enable_low));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic conclude();
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [19:0] e, input logic [19:0] g);
    n_tests++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", name, e, g);
      err_count++;
    end
  endtask
  task automatic push(input logic [19:0] d);
    int i;
    cmd_valid <= 1'b1;
    cmd_data <= d;
    exp_ctrl.push_back(d);
    exp_resp.push_back(status[sel]);
    if (d[19:17] == 3'h7) sel = d[5:4];
    for (i = 0; i < 5000; i++) begin
      @(posedge clk);
      if (cmd_ready === 1'b1) break;
    end
    chk("push wait", 20'h00000, (i == 5000) ? 20'h00001 : 20'h00000);
  endtask
  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  always @(posedge clk) begin
    if (ctrl_stb === 1'b1) begin
      if (exp_ctrl.size() == 0) exp_ctrl.push_back(~ctrl);
      chk("control word", exp_ctrl.pop_front(), ctrl);
    end
    if (resp_valid === 1'b1) begin
      if (exp_resp.size() == 0) exp_resp.push_back(~resp_data);
      chk("status word", exp_resp.pop_front(), resp_data);
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int i;
    nrst = 1'b0;
    cmd_valid = 1'b0;
    cmd_data = 20'h00000;
    drv_en = 1'b0;
    err_count = 0;
    n_tests = 0;
    sel = 2'h0;
    r = $urandom(32'hC95870EC);
    for (int k = 0; k < 4; k++) status[k] = 20'($urandom);
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    push(20'hFFFFF);
    push(20'h00001);
    for (int s = 0; s < 4; s++) begin
      push({3'h7, 11'($urandom), 2'(s), 4'($urandom)});
      push({1'b0, 19'($urandom)});
    end
    cmd_valid <= 1'b0;
    for (i = 0; i < 20000 && exp_ctrl.size() + exp_resp.size() > 0; i++) @(posedge clk);
    chk("pending", 20'h00000, 20'(exp_ctrl.size() + exp_resp.size()));
    chk("readback select", {18'h00000, sel}, {18'h00000, rb_sel});
    drv_en <= 1'b1;
    @(posedge clk);
    drv_en <= 1'b0;
    repeat (20) begin
      @(posedge clk);
      chk("enable glitch", 20'h00000, {19'h00000, drv_en_o});
    end
    drv_en <= 1'b1;
    for (i = 0; i < 20 && drv_en_o !== 1'b1; i++) @(posedge clk);
    chk("driver enable", 20'h00001, {19'h00000, drv_en_o});
    conclude();
  end
endmodule // tb
`default_nettype wire
